/* core/dram_cmd_pkg.sv */
// constants shared by the command decoder and its bank timer
package dram_cmd_pkg;
	localparam int NUM_BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ADDR_W = 12;
	localparam int ROW_W = 12;
	localparam int COL_W = 9;
	localparam int BYTE_LANES = 4;
	localparam int AP_BIT = 8;
	localparam int COL_HI_BIT = 9;
	localparam int COL_LO_BITS = 8;
	// command codes as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// data terminator disable snoop: ras_n, cas_n, we_n only
	localparam logic [2:0] SNOOP_READ = 3'h5;
	// mode register selection by {bank_select_bit1, bank_select_bit0}
	localparam logic [1:0] MODE_SEL_MAIN = 2'h0;
	localparam logic [1:0] MODE_SEL_EXT = 2'h1;
	localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
	// timing defaults, in link clock cycles
	localparam int ROW_PRECHARGE_CYC = 4;
	localparam int MIN_ROW_ACTIVE_CYC = 8;
	localparam int READ_LATENCY_CYC = 7;
	localparam int BURST_COUNT = 4;
	localparam int TIMER_W = 8;
	localparam logic [ROW_W-1:0] REFRESH_ROW_RESET = 12'h000;
endpackage

/* core/bank_timer.sv */
// per-bank row state with row-active and precharge timing
`timescale 1ns/1ps
module bank_timer
	import dram_cmd_pkg::*;
#(
	parameter int T_RAS = MIN_ROW_ACTIVE_CYC,
	parameter int T_RP = ROW_PRECHARGE_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_activate,
	input wire logic i_precharge,
	input wire logic i_auto_pre_arm,
	input wire logic [ROW_W-1:0] i_row,
	output logic o_open,
	output logic o_idle,
	output logic [ROW_W-1:0] o_row
);
	typedef enum logic [1:0] {
		BK_IDLE = 2'b00,
		BK_OPEN = 2'b01,
		BK_PRECHARGING = 2'b10
	} bank_state_e;

	typedef struct packed {
		bank_state_e st;
		logic [TIMER_W-1:0] ras_cnt;
		logic [TIMER_W-1:0] rp_cnt;
		logic ap_pending;
		logic [ROW_W-1:0] row;
	} bank_s;

	bank_s s_reg;
	bank_s s_next;

	// counters are eight bits wide, so longer timings cannot be held
	if (T_RAS < 1 || T_RAS > 255 || T_RP < 1 || T_RP > 255) begin : g_bad_cfg
		$error("bank_timer: timing out of range");
	end

	// row stays open until a precharge; auto precharge waits for row-active
	always_comb begin
		s_next = s_reg;
		if (s_reg.ras_cnt != '0) begin
			s_next.ras_cnt = s_reg.ras_cnt - 1'b1;
		end
		case (s_reg.st)
			BK_IDLE: begin
				if (i_activate) begin
					s_next.st = BK_OPEN;
					s_next.row = i_row;
					s_next.ras_cnt = TIMER_W'(T_RAS - 1);
					s_next.ap_pending = 1'b0;
				end
			end
			BK_OPEN: begin
				if (i_auto_pre_arm) begin
					s_next.ap_pending = 1'b1;
				end
				// earliest legal precharge point honours row-active time
				if ((i_precharge || s_reg.ap_pending) &&
						s_reg.ras_cnt == '0) begin
					s_next.st = BK_PRECHARGING;
					s_next.rp_cnt = TIMER_W'(T_RP - 1);
					s_next.ap_pending = 1'b0;
				end else if (i_precharge) begin
					s_next.ap_pending = 1'b1; // early precharge held off
				end
			end
			BK_PRECHARGING: begin
				if (s_reg.rp_cnt == '0) begin
					s_next.st = BK_IDLE;
				end else begin
					s_next.rp_cnt = s_reg.rp_cnt - 1'b1;
				end
			end
			default: begin
				s_next.st = BK_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '{BK_IDLE, '0, '0, 1'b0, '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_open = (s_reg.st == BK_OPEN);
	assign o_idle = (s_reg.st == BK_IDLE);
	assign o_row = s_reg.row;
endmodule

/* core/dram_command_decoder.sv */
// command decoder, bank control, refresh and termination control
`timescale 1ns/1ps
module dram_command_decoder
	import dram_cmd_pkg::*;
#(
	parameter int READ_LATENCY = READ_LATENCY_CYC,
	parameter int BURST = BURST_COUNT,
	parameter int T_RAS = MIN_ROW_ACTIVE_CYC,
	parameter int T_RP = ROW_PRECHARGE_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_mem_clk,
	input wire logic i_clk_enable,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic i_bank_select_bit0,
	input wire logic i_bank_select_bit1,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [BYTE_LANES-1:0] i_byte_write_mask,
	output logic [BANK_W-1:0] o_access_bank,
	output logic [COL_W-1:0] o_access_col,
	output logic o_read_start,
	output logic o_write_start,
	output logic [BYTE_LANES-1:0] o_byte_write_en,
	output logic o_refresh_pulse,
	output logic [ROW_W-1:0] o_refresh_row,
	output logic [ADDR_W-1:0] o_mode_main,
	output logic [ADDR_W-1:0] o_mode_ext,
	output logic o_term_disable,
	output logic o_self_refresh,
	output logic o_dll_enable,
	output logic o_dll_reset,
	output logic o_bank_open_sync,
	output logic o_self_refresh_sync
);
	localparam int TERM_LEN = BURST / 2 + 2;
	localparam int TERM_DLY = READ_LATENCY - 1;
	// the capture flop is stage 0, so the window starts one stage early
	localparam int TERM_FIRST = TERM_DLY - 1;
	localparam int TERM_PIPE = TERM_FIRST + TERM_LEN;

	typedef struct packed {
		logic [3:0] cmd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic [BYTE_LANES-1:0] mask;
		logic cke;
		logic prev_cke;
		logic [BANK_W-1:0] acc_bank;
		logic [COL_W-1:0] acc_col;
		logic rd;
		logic wr;
		logic [BYTE_LANES-1:0] wen;
		logic ref_p;
		logic [ROW_W-1:0] ref_row;
		logic [ADDR_W-1:0] mode_main;
		logic [ADDR_W-1:0] mode_ext;
		logic [TERM_PIPE-1:0] snoop;
		logic term_dis;
		logic self_ref;
		logic dll_en;
		logic dll_rst;
		logic any_open;
	} link_s;

	typedef struct packed {
		logic [1:0] open_sync;
		logic [1:0] sr_sync;
		logic open_q;
		logic sr_q;
	} core_s;

	link_s l_reg;
	link_s l_next;
	core_s c_reg;
	core_s c_next;
	logic [NUM_BANKS-1:0] act_v;
	logic [NUM_BANKS-1:0] pre_v;
	logic [NUM_BANKS-1:0] ap_v;
	logic [NUM_BANKS-1:0] open_v;
	logic [NUM_BANKS-1:0] idle_v;
	logic cmd_live;

	// refuse settings that the snoop pipe cannot serve
	if (READ_LATENCY < 2 || BURST < 2 || BURST % 2 != 0) begin : g_bad_cfg
		$error("dram_command_decoder: unsupported latency or burst");
	end

	// a command is taken only while enable was high before and now
	assign cmd_live = l_reg.cke && l_reg.prev_cke && !l_reg.self_ref;

	// per-bank strobes from the registered command
	always_comb begin
		act_v = '0;
		pre_v = '0;
		ap_v = '0;
		if (cmd_live) begin
			case (l_reg.cmd)
				CMD_ACTIVATE: begin
					// a bank still open or precharging ignores it
					act_v[l_reg.bank] = idle_v[l_reg.bank];
				end
				CMD_PRECHARGE: begin
					if (l_reg.addr[AP_BIT]) begin
						pre_v = '1;
					end else begin
						pre_v[l_reg.bank] = 1'b1;
					end
				end
				CMD_READ, CMD_WRITE: begin
					ap_v[l_reg.bank] = l_reg.addr[AP_BIT];
				end
				default: begin
					act_v = '0;
				end
			endcase
		end
	end

	// one timer per bank, all on the link clock
	genvar gb;
	generate
		for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
			bank_timer #(
				.T_RAS(T_RAS),
				.T_RP(T_RP)
			) u_bank (
				.i_clk(i_mem_clk),
				.i_rst(i_rst),
				.i_activate(act_v[gb]),
				.i_precharge(pre_v[gb]),
				.i_auto_pre_arm(ap_v[gb]),
				.i_row(l_reg.addr[ROW_W-1:0]),
				.o_open(open_v[gb]),
				.o_idle(idle_v[gb]),
				.o_row()
			);
		end
	endgenerate

	// link-side decode; all pulses last one link clock
	always_comb begin
		l_next = l_reg;
		l_next.prev_cke = l_reg.cke;
		l_next.cke = i_clk_enable;
		l_next.rd = 1'b0;
		l_next.wr = 1'b0;
		l_next.wen = '0;
		l_next.ref_p = 1'b0;
		l_next.dll_rst = 1'b0;
		l_next.any_open = |open_v; // registered before it crosses
		// capture while enable is high or has just fallen, so that a
		// refresh code on the falling edge can start self refresh
		if (i_clk_enable || l_reg.cke) begin
			l_next.cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
			l_next.bank = {i_bank_select_bit1, i_bank_select_bit0};
			l_next.addr = i_addr;
			l_next.mask = i_byte_write_mask;
		end else if (!l_reg.cke) begin
			l_next.cmd = CMD_NOP;
		end
		// snoop ignores chip select so both ranks kill termination
		l_next.snoop = {l_reg.snoop[TERM_PIPE-2:0],
			i_clk_enable && {i_ras_n, i_cas_n, i_we_n} == SNOOP_READ};
		l_next.term_dis = 1'b0;
		// window opens read_latency - 1 edges after the snooped read
		for (int k = TERM_FIRST; k < TERM_PIPE; k++) begin
			if (l_reg.snoop[k]) begin
				l_next.term_dis = 1'b1;
			end
		end
		// self refresh entry: refresh code while enable drops
		if (!l_reg.self_ref && l_reg.prev_cke && !l_reg.cke &&
				l_reg.cmd == CMD_REFRESH) begin
			l_next.self_ref = 1'b1;
			l_next.dll_en = 1'b0;
		end else if (l_reg.self_ref && l_reg.cke) begin
			l_next.self_ref = 1'b0;
			l_next.dll_en = 1'b1;
			l_next.dll_rst = 1'b1;
		end
		// termination follows the self refresh state on the same edge
		if (l_next.self_ref) begin
			l_next.term_dis = 1'b1;
		end
		if (cmd_live) begin
			// deselect and nop fall to default and take nothing
			case (l_reg.cmd)
				CMD_READ, CMD_WRITE: begin
					// an access to an unopened bank is dropped
					if (open_v[l_reg.bank]) begin
						l_next.acc_bank = l_reg.bank;
						l_next.acc_col = {l_reg.addr[COL_HI_BIT],
							l_reg.addr[COL_LO_BITS-1:0]};
						l_next.rd = (l_reg.cmd == CMD_READ);
						l_next.wr = (l_reg.cmd == CMD_WRITE);
						if (l_reg.cmd == CMD_WRITE) begin
							l_next.wen = ~l_reg.mask;
						end
					end
				end
				CMD_REFRESH: begin
					// row comes from the counter, address pins unused
					l_next.ref_p = 1'b1;
					l_next.ref_row = l_reg.ref_row + 1'b1;
				end
				CMD_MODE_LOAD: begin
					if (l_reg.bank == MODE_SEL_MAIN) begin
						l_next.mode_main = l_reg.addr;
					end else if (l_reg.bank == MODE_SEL_EXT) begin
						l_next.mode_ext = l_reg.addr;
					end
				end
				default: begin
					l_next.ref_p = 1'b0;
				end
			endcase
		end
	end

	// link flops: enable low, loop on and nothing pending after reset
	always_ff @(posedge i_mem_clk or posedge i_rst) begin
		if (i_rst) begin
			l_reg <= '0;
			l_reg.cmd <= CMD_NOP;
			l_reg.ref_row <= REFRESH_ROW_RESET;
			l_reg.mode_main <= MODE_RESET;
			l_reg.mode_ext <= MODE_RESET;
			l_reg.dll_en <= 1'b1;
		end else begin
			l_reg <= l_next;
		end
	end

	// status crosses to the reference clock through three flops each
	always_comb begin
		c_next = c_reg;
		c_next.open_sync = {c_reg.open_sync[0], l_reg.any_open};
		c_next.sr_sync = {c_reg.sr_sync[0], l_reg.self_ref};
		c_next.open_q = c_reg.open_sync[1];
		c_next.sr_q = c_reg.sr_sync[1];
	end

	// status flops on the reference clock
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			c_reg <= '0;
		end else begin
			c_reg <= c_next;
		end
	end

	// access bank and column held until the next accepted access; start strobes and byte enables last one link clock
	assign o_access_bank = l_reg.acc_bank;
	assign o_access_col = l_reg.acc_col;
	assign o_read_start = l_reg.rd;
	assign o_write_start = l_reg.wr;
	assign o_byte_write_en = l_reg.wen;

	// refresh and mode register state
	assign o_refresh_pulse = l_reg.ref_p;
	assign o_refresh_row = l_reg.ref_row;
	assign o_mode_main = l_reg.mode_main;
	assign o_mode_ext = l_reg.mode_ext;

	// termination and loop control
	assign o_term_disable = l_reg.term_dis;
	assign o_self_refresh = l_reg.self_ref;
	assign o_dll_enable = l_reg.dll_en;
	assign o_dll_reset = l_reg.dll_rst;

	// status already resynchronised to the reference clock
	assign o_bank_open_sync = c_reg.open_q;
	assign o_self_refresh_sync = c_reg.sr_q;
endmodule

/* dv/dram_cmd_sva.sv */
// concurrent checks on the command decoder ports
`timescale 1ns/1ps
module dram_cmd_sva
	import dram_cmd_pkg::*;
#(
	parameter int READ_LATENCY = READ_LATENCY_CYC
) (
	input wire logic i_mem_clk,
	input wire logic i_rst,
	input wire logic i_clk_enable,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [BYTE_LANES-1:0] i_byte_write_mask,
	input wire logic [COL_W-1:0] o_access_col,
	input wire logic o_read_start,
	input wire logic o_write_start,
	input wire logic [BYTE_LANES-1:0] o_byte_write_en,
	input wire logic o_refresh_pulse,
	input wire logic o_term_disable,
	input wire logic o_self_refresh,
	input wire logic o_dll_enable,
	input wire logic o_dll_reset
);
	wire logic [3:0] cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
	default clocking @(posedge i_mem_clk);
	endclocking
	default disable iff (i_rst);
	// every pulse must trace back to its command two edges earlier
	rd_cause_a: assert property (
		o_read_start |-> $past(cmd, 2) == CMD_READ) else $error("bad read");
	wr_cause_a: assert property (
		o_write_start |-> $past(cmd, 2) == CMD_WRITE) else $error("bad write");
	wr_mask_a: assert property (
		o_write_start |-> o_byte_write_en == ~$past(i_byte_write_mask, 2))
		else $error("bad byte enables");
	col_map_a: assert property (
		o_write_start |-> o_access_col == {$past(i_addr[9], 2),
		$past(i_addr[7:0], 2)}) else $error("bad column");
	// self refresh also raises the disable, so it is excluded here
	term_len_a: assert property (
		$rose(o_term_disable) && !o_self_refresh |->
		o_term_disable [*4] ##1 !o_term_disable) else $error("bad length");
	term_start_a: assert property (
		$rose(o_term_disable) && !o_self_refresh |-> $past({i_ras_n,
		i_cas_n, i_we_n}, READ_LATENCY) == SNOOP_READ)
		else $error("bad start");
	ref_cause_a: assert property (
		o_refresh_pulse |-> $past(cmd, 2) == CMD_REFRESH &&
		$past(i_clk_enable, 2)) else $error("bad refresh");
	sr_off_a: assert property (
		o_self_refresh |-> !o_dll_enable && o_term_disable)
		else $error("loop on in self refresh");
	dll_reset_a: assert property (
		o_dll_reset |-> $past(o_self_refresh) && !o_self_refresh)
		else $error("stray loop reset");
	sr_entry_a: assert property (
		$rose(o_self_refresh) |-> $past(cmd, 2) == CMD_REFRESH &&
		!$past(i_clk_enable, 2)) else $error("bad self refresh entry");
endmodule
bind dram_command_decoder dram_cmd_sva #(
	.READ_LATENCY(READ_LATENCY)
) chk (
	.i_mem_clk(i_mem_clk),
	.i_rst(i_rst),
	.i_clk_enable(i_clk_enable),
	.i_cs_n(i_cs_n),
	.i_ras_n(i_ras_n),
	.i_cas_n(i_cas_n),
	.i_we_n(i_we_n),
	.i_addr(i_addr),
	.i_byte_write_mask(i_byte_write_mask),
	.o_access_col(o_access_col),
	.o_read_start(o_read_start),
	.o_write_start(o_write_start),
	.o_byte_write_en(o_byte_write_en),
	.o_refresh_pulse(o_refresh_pulse),
	.o_term_disable(o_term_disable),
	.o_self_refresh(o_self_refresh),
	.o_dll_enable(o_dll_enable),
	.o_dll_reset(o_dll_reset)
);

/* dv/mem_ctrl_model.sv */
// memory controller model driving the command pins
`timescale 1ns/1ps
module mem_ctrl_model
	import dram_cmd_pkg::*;
(
	input wire logic i_mem_clk,
	output logic o_cke,
	output logic [3:0] o_cmd,
	output logic [1:0] o_bank,
	output logic [ADDR_W-1:0] o_addr,
	output logic [BYTE_LANES-1:0] o_mask
);
	initial begin
		o_cke = 1'b1;
		o_cmd = CMD_NOP;
		o_bank = 2'h0;
		o_addr = 12'h000;
		o_mask = 4'hF;
	end
	// one command, then nops; address and mask pins invert so nothing stale is seen
	task automatic issue(input logic [3:0] c, input logic [1:0] b,
		input logic [ADDR_W-1:0] a, input logic [3:0] m, input logic k,
		input int gap);
		@(posedge i_mem_clk);
		o_cke <= k;
		o_cmd <= c;
		o_bank <= b;
		o_addr <= a;
		o_mask <= m;
		@(posedge i_mem_clk);
		o_cmd <= CMD_NOP;
		o_addr <= ~a;
		o_mask <= ~m;
		repeat (gap) @(posedge i_mem_clk);
	endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
`define C(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("MISMATCH t=%0t got %0h", $time, got); \
	end \
end
module testbench;
	import dram_cmd_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_mem_clk = 1'b0;
	logic i_rst = 1'b1;
	wire i_clk_enable, i_cs_n, i_ras_n, i_cas_n, i_we_n;
	wire i_bank_select_bit0, i_bank_select_bit1;
	wire [ADDR_W-1:0] i_addr;
	wire [BYTE_LANES-1:0] i_byte_write_mask;
	logic [BANK_W-1:0] o_access_bank;
	logic [COL_W-1:0] o_access_col;
	logic o_read_start, o_write_start, o_refresh_pulse, o_term_disable;
	logic o_self_refresh, o_dll_enable, o_dll_reset;
	logic dll_seen = 1'b0;
	logic o_bank_open_sync, o_self_refresh_sync;
	logic [BYTE_LANES-1:0] o_byte_write_en, ben;
	logic [ROW_W-1:0] o_refresh_row, row0;
	logic [ADDR_W-1:0] o_mode_main, o_mode_ext;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	int rd = 0;
	int wr = 0;
	int th = 0;
	int rf = 0;
	dram_command_decoder dut (.*);
	mem_ctrl_model ctrl (
		.i_mem_clk(i_mem_clk),
		.o_cke(i_clk_enable),
		.o_cmd({i_cs_n, i_ras_n, i_cas_n, i_we_n}),
		.o_bank({i_bank_select_bit1, i_bank_select_bit0}),
		.o_addr(i_addr),
		.o_mask(i_byte_write_mask)
	);
	initial forever #5 i_ref_clk = ~i_ref_clk;
	// link clock offset so its edges never line up with the system clock
	initial begin
		#3;
		forever #7.5 i_mem_clk = ~i_mem_clk;
	end
	// totals of pulses let scenarios judge dropped commands
	always @(posedge i_mem_clk) begin
		if (o_read_start === 1'b1) rd++;
		if (o_write_start === 1'b1) wr++;
		if (o_write_start === 1'b1) ben <= o_byte_write_en;
		if (o_term_disable === 1'b1) th++;
		if (o_refresh_pulse === 1'b1) rf++;
		if (o_dll_reset === 1'b1) dll_seen <= 1'b1;
	end
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 4000) failures++;
		if (cycles == 4000) conclude();
	end
	task automatic go(input logic [3:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic [3:0] m, input int gap);
		ctrl.issue(c, b, a, m, 1'b1, gap);
	endtask
	task automatic t_access();
		go(CMD_ACTIVATE, 2'h2, 12'h3C1, 4'hF, 0);
		go(CMD_WRITE, 2'h2, 12'h2A5, 4'h5, 3);
		`C(wr, 1)
		`C(ben, 4'hA)
		`C(o_access_bank, 2'h2)
		`C(o_access_col, 9'h1A5)
		`C(o_bank_open_sync, 1'b1)
		go(CMD_WRITE, 2'h1, 12'h000, 4'h0, 3);
		`C(wr, 1)
	endtask
	// no read and no self refresh before here, so th starts at zero
	task automatic t_read();
		go(4'hD, 2'h2, 12'h000, 4'hF, 14);
		`C(rd, 0)
		`C(th, 4)
		go(CMD_READ, 2'h2, 12'h0FF, 4'hF, 14);
		`C(rd, 1)
		`C(th, 8)
		`C(o_access_col, 9'h0FF)
	endtask
	task automatic t_prech();
		go(CMD_PRECHARGE, 2'h2, 12'h000, 4'hF, 8);
		go(CMD_WRITE, 2'h2, 12'h000, 4'h0, 3);
		`C(wr, 1)
		go(CMD_ACTIVATE, 2'h0, 12'h001, 4'hF, 0);
		go(CMD_WRITE, 2'h0, 12'h100, 4'h0, 16);
		go(CMD_WRITE, 2'h0, 12'h000, 4'h0, 3);
		`C(wr, 2)
		go(CMD_ACTIVATE, 2'h0, 12'h002, 4'hF, 0);
		go(CMD_WRITE, 2'h0, 12'h000, 4'h0, 3);
		`C(wr, 3)
		go(CMD_ACTIVATE, 2'h3, 12'h003, 4'hF, 0);
		go(CMD_PRECHARGE, 2'h1, 12'h100, 4'hF, 14);
		go(CMD_WRITE, 2'h3, 12'h000, 4'h0, 0);
		go(CMD_WRITE, 2'h0, 12'h000, 4'h0, 3);
		`C(wr, 3)
		`C(o_bank_open_sync, 1'b0)
	endtask
	task automatic t_mode();
		go(CMD_MODE_LOAD, 2'h0, 12'h123, 4'hF, 3);
		go(CMD_MODE_LOAD, 2'h1, 12'h456, 4'hF, 3);
		go(CMD_MODE_LOAD, 2'h3, 12'hFFF, 4'hF, 3);
		go(CMD_MODE_LOAD, 2'h2, 12'hEEE, 4'hF, 3);
		`C(o_mode_main, 12'h123)
		`C(o_mode_ext, 12'h456)
	endtask
	task automatic t_self();
		row0 = o_refresh_row;
		go(CMD_REFRESH, 2'h3, 12'hABC, 4'hF, 8);
		go(CMD_REFRESH, 2'h0, 12'h555, 4'hF, 8);
		`C(o_refresh_row, row0 + 12'h002)
		`C(rf, 2)
		ctrl.issue(CMD_REFRESH, 2'h0, 12'h000, 4'hF, 1'b0, 4);
		`C(o_self_refresh, 1'b1)
		`C(o_dll_enable, 1'b0)
		`C(o_term_disable, 1'b1)
		repeat (4) @(posedge i_ref_clk);
		`C(o_self_refresh_sync, 1'b1)
		go(CMD_NOP, 2'h0, 12'h000, 4'hF, 3);
		`C(o_self_refresh, 1'b0)
		`C(o_dll_enable, 1'b1)
		`C(dll_seen, 1'b1)
		`C(rf, 2)
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_mem_clk);
		`C(o_dll_enable, 1'b1)
		`C(o_mode_main, MODE_RESET)
		t_access();
		t_read();
		t_prech();
		t_mode();
		t_self();
		conclude();
	end
endmodule
